// File: mxsp_host.sv
// Host controller that drives a multiplexed address/data static memory port.
// Assumes the memory pins are wired straight to these ports; bus turnaround by testbench.
// Function
// RL1 - Device loads address latches only on rising edge of matching strobe.
// RL2 - Low address strobe captures the eight low address bits.
// RL3 - High address strobe captures five upper bits, forming thirteen-bit address.
// RL4 - Address halves may be strobed in either order.
// RL5 - Latched halves persist until re-strobed; unchanged halves may be skipped.
// RL6 - For a write, data goes on the bus before write strobe asserts.
// RL7 - Device drives stored byte only while read strobe is asserted.
// RL8 - Host never asserts read and write strobes together.
// RL9 - Read and write strobes need chip enable asserted first.
// RL10 - Top three bus lines ignored when capturing the upper address half.
// RL11 - Write uses the latest latched upper and lower halves.
`timescale 1ns/10ps
`default_nettype none
`include "mxsp_map.svh"
module mxsp_host
    import mxsp_pkg::*;
#(
    parameter int ADDR_W = 13
) (
    input  wire  logic        i_clk_sys,
    input  wire  logic        i_rst_b,
    input  wire  logic        i_req,
    input  wire  logic        i_req_write,
    input  wire  logic [12:0] i_req_addr,
    input  wire  logic [7:0]  i_req_wdata,
    output logic              o_req_ready,
    output logic              o_rsp_valid,
    output logic [7:0]        o_rsp_rdata,
    output logic              o_chip_en_n,
    output logic              o_low_addr_strobe_n,
    output logic              o_high_addr_strobe_n,
    output logic              o_read_en_n,
    output logic              o_write_en_n,
    input  wire  logic [7:0]  i_shared_addr_data_bus,
    output logic [7:0]        o_shared_addr_data_bus,
    output logic              o_shared_addr_data_bus_oe
);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] C_SET  = CNT_W'(`MXSP_CYC(`MXSP_T_ADDR_SETUP_NS));
    localparam logic [CNT_W-1:0] C_STB  = CNT_W'(`MXSP_CYC(`MXSP_T_STRB_LOW_NS));
    localparam logic [CNT_W-1:0] C_GAP  = CNT_W'(`MXSP_CYC(`MXSP_T_STRB_TO_RW_NS));
    localparam logic [CNT_W-1:0] C_DSET = CNT_W'(`MXSP_CYC(`MXSP_T_DATA_SETUP_NS));
    localparam logic [CNT_W-1:0] C_WR   = CNT_W'(`MXSP_CYC(`MXSP_T_WR_LOW_NS));
    // Two spare cycles so the access time is met after the input synchroniser
    localparam logic [CNT_W-1:0] C_RD   = CNT_W'(`MXSP_CYC(`MXSP_T_RD_ACCESS_NS) + 2);
    localparam logic [CNT_W-1:0] C_HIZ  = CNT_W'(`MXSP_CYC(`MXSP_T_RD_HIZ_NS));

    if (ADDR_W != `MXSP_LO_ADDR_W + `MXSP_HI_ADDR_W) begin : g_bad_addr_w
        $error("mxsp_host: ADDR_W must be 13");
    end

    ////////////////////////////////////////////////////////////////////////////////
    mxsp_state_t      state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             wr_q;
    logic [12:0]      addr_q;
    logic [7:0]       wdata_q;
    logic [12:0]      shadow_q;
    logic             shadow_ok_q;
    logic [7:0]       bus_s1_q;
    logic [7:0]       bus_s2_q;
    logic             done;
    logic             lo_same;
    logic             hi_same;

    assign done        = (cnt_q == '0);
    assign lo_same     = shadow_ok_q && (shadow_q[7:0] == addr_q[7:0]);
    assign hi_same     = shadow_ok_q && (shadow_q[12:8] == addr_q[12:8]);
    assign o_req_ready = (state_q == MXSP_IDLE);

    // Two-flop synchroniser on the shared bus input
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_s1_q <= 8'h00;
            bus_s2_q <= 8'h00;
        end else begin
            bus_s1_q <= i_shared_addr_data_bus;
            bus_s2_q <= bus_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: low half then high half, skipping halves already latched
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= MXSP_IDLE;
            cnt_q   <= '0;
        end else begin
            if (!done)
                cnt_q <= cnt_q - 1'b1;
            unique case (state_q)
                MXSP_IDLE: begin
                    if (i_req) begin
                        state_q <= MXSP_LO_SET;
                        cnt_q   <= C_SET;
                    end
                end
                MXSP_LO_SET: begin
                    if (lo_same) begin // see RL5
                        state_q <= MXSP_HI_SET;
                        cnt_q   <= C_SET;
                    end else if (done) begin
                        state_q <= MXSP_LO_STB;
                        cnt_q   <= C_STB;
                    end
                end
                MXSP_LO_STB: begin
                    if (done) begin
                        state_q <= MXSP_HI_SET;
                        cnt_q   <= C_SET;
                    end
                end
                MXSP_HI_SET: begin
                    if (hi_same) begin // see RL5
                        state_q <= MXSP_GAP;
                        cnt_q   <= C_GAP;
                    end else if (done) begin
                        state_q <= MXSP_HI_STB;
                        cnt_q   <= C_STB;
                    end
                end
                MXSP_HI_STB: begin
                    if (done) begin
                        state_q <= MXSP_GAP;
                        cnt_q   <= C_GAP;
                    end
                end
                MXSP_GAP: begin
                    if (done) begin
                        state_q <= wr_q ? MXSP_WR_SET : MXSP_RD_STB;
                        cnt_q   <= wr_q ? C_DSET : C_RD;
                    end
                end
                MXSP_WR_SET: begin
                    if (done) begin // see RL6
                        state_q <= MXSP_WR_STB;
                        cnt_q   <= C_WR;
                    end
                end
                MXSP_WR_STB: begin
                    if (done)
                        state_q <= MXSP_IDLE;
                end
                MXSP_RD_STB: begin
                    if (done) begin
                        state_q <= MXSP_RD_HIZ;
                        cnt_q   <= C_HIZ;
                    end
                end
                MXSP_RD_HIZ: begin
                    if (done)
                        state_q <= MXSP_IDLE;
                end
                default: state_q <= MXSP_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request capture and memory of what the device has latched
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q    <= 1'b0;
            addr_q  <= 13'h0000;
            wdata_q <= 8'h00;
        end else if (state_q == MXSP_IDLE && i_req) begin
            wr_q    <= i_req_write;
            addr_q  <= i_req_addr;
            wdata_q <= i_req_wdata;
        end
    end

    // Shadow is only trusted once both halves were strobed since reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shadow_q    <= 13'h0000;
            shadow_ok_q <= 1'b0;
        end else begin
            if (state_q == MXSP_LO_STB && done)
                shadow_q[7:0] <= addr_q[7:0]; // see RL2
            if (state_q == MXSP_HI_STB && done) begin
                shadow_q[12:8] <= addr_q[12:8]; // see RL3
                shadow_ok_q    <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered so no glitch reaches the strobes
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_chip_en_n          <= 1'b1;
            o_low_addr_strobe_n  <= 1'b1;
            o_high_addr_strobe_n <= 1'b1;
            o_read_en_n          <= 1'b1;
            o_write_en_n         <= 1'b1;
        end else begin
            // Rising strobe edge on leaving the strobe state latches the half
            o_low_addr_strobe_n  <= !(state_q == MXSP_LO_SET && done && !lo_same)
                                    && !(state_q == MXSP_LO_STB && !done); // see RL1
            o_high_addr_strobe_n <= !(state_q == MXSP_HI_SET && done && !hi_same)
                                    && !(state_q == MXSP_HI_STB && !done); // see RL4
            // Chip enable goes low a gap ahead of either data strobe
            o_chip_en_n  <= !(state_q inside {MXSP_GAP, MXSP_WR_SET, MXSP_WR_STB,
                                              MXSP_RD_STB, MXSP_RD_HIZ}); // see RL9
            o_write_en_n <= !((state_q == MXSP_WR_SET && done)
                              || (state_q == MXSP_WR_STB && !done)); // see RL11
            o_read_en_n  <= !((state_q == MXSP_GAP && done && !wr_q)
                              || (state_q == MXSP_RD_STB && !done)); // see RL8
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_shared_addr_data_bus    <= 8'h00;
            o_shared_addr_data_bus_oe <= 1'b0;
        end else begin
            unique case (state_q)
                MXSP_LO_SET, MXSP_LO_STB: begin
                    o_shared_addr_data_bus    <= addr_q[7:0];
                    o_shared_addr_data_bus_oe <= 1'b1;
                end
                MXSP_HI_SET, MXSP_HI_STB: begin
                    o_shared_addr_data_bus    <= {`MXSP_HI_UNUSED_VAL, addr_q[12:8]}; // see RL10
                    o_shared_addr_data_bus_oe <= 1'b1;
                end
                MXSP_GAP, MXSP_WR_SET, MXSP_WR_STB: begin
                    o_shared_addr_data_bus    <= wdata_q;
                    o_shared_addr_data_bus_oe <= wr_q;
                end
                default: begin
                    o_shared_addr_data_bus    <= 8'h00;
                    o_shared_addr_data_bus_oe <= 1'b0; // see RL7
                end
            endcase
        end
    end

    // Sample the read byte at the end of the read strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 8'h00;
        end else begin
            o_rsp_valid <= (state_q == MXSP_RD_STB && done)
                           || (state_q == MXSP_WR_STB && done);
            if (state_q == MXSP_RD_STB && done)
                o_rsp_rdata <= bus_s2_q; // see RL7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_rw_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL8
        !(!o_read_en_n && !o_write_en_n))
        else $error("read and write strobes low together");

    a_ce_before_rw: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL9
        $fell(o_read_en_n) || $fell(o_write_en_n) |-> !$past(o_chip_en_n))
        else $error("data strobe without prior chip enable");

    sequence s_data_ready;
        o_shared_addr_data_bus_oe ##1 o_shared_addr_data_bus_oe;
    endsequence
    a_wr_data_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL6
        $fell(o_write_en_n) |-> $past(o_shared_addr_data_bus_oe, 3))
        else $error("write strobe before data setup");

    a_wr_hold_data: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL11
        !o_write_en_n |-> s_data_ready)
        else $error("data released during write strobe");

    a_rd_bus_free: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL7
        !o_read_en_n |-> !o_shared_addr_data_bus_oe)
        else $error("host drives bus during read");

    a_hi_top_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL10
        !o_high_addr_strobe_n |-> o_shared_addr_data_bus[7:5] == 3'h0)
        else $error("upper bus lines not zero on high strobe");

    a_strobe_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL1
        $fell(o_low_addr_strobe_n) |-> !o_low_addr_strobe_n [*1] ##1 o_shared_addr_data_bus_oe)
        else $error("low strobe too short or bus released");

    a_strobes_apart: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL4
        !(!o_low_addr_strobe_n && !o_high_addr_strobe_n))
        else $error("both address strobes low together");

    a_rsp_bounded: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // see RL5
        o_req_ready && i_req |-> ##[4:40] o_rsp_valid)
        else $error("access did not finish in time");
endmodule : mxsp_host
`default_nettype wire

// File: mxsp_map.svh
// Timing counts and pin field layout for the multiplexed memory host port.
// Assumes the includer runs on a 40 MHz system clock (25 ns period).
`ifndef MXSP_MAP_SVH
`define MXSP_MAP_SVH

`define MXSP_CLK_PERIOD_NS   25
`define MXSP_LO_ADDR_LSB     0
`define MXSP_LO_ADDR_W       8
`define MXSP_HI_ADDR_LSB     8
`define MXSP_HI_ADDR_W       5
`define MXSP_HI_UNUSED_VAL   3'h0
// Strobe low width, setup and access times in ns
`define MXSP_T_STRB_LOW_NS   15
`define MXSP_T_ADDR_SETUP_NS 20
`define MXSP_T_STRB_TO_RW_NS 15
`define MXSP_T_DATA_SETUP_NS 60
`define MXSP_T_WR_LOW_NS     50
`define MXSP_T_RD_ACCESS_NS  70
`define MXSP_T_RD_HIZ_NS     25
// Least times round up to whole cycles
`define MXSP_CYC(ns) (((ns) + `MXSP_CLK_PERIOD_NS - 1) / `MXSP_CLK_PERIOD_NS)

`endif

// File: mxsp_mem_model.sv
// Behavioural model of the multiplexed address/data static memory.
// Assumes the bench resolves the shared bus and feeds the wire level back in.
`timescale 1ns/10ps
`default_nettype none
module mxsp_mem_model (
    input  wire logic       i_chip_en_n,
    input  wire logic       i_low_addr_strobe_n,
    input  wire logic       i_high_addr_strobe_n,
    input  wire logic       i_read_en_n,
    input  wire logic       i_write_en_n,
    input  wire logic [7:0] i_bus,
    output logic      [7:0] o_bus,
    output logic            o_bus_oe,
    output logic      [1:0] o_err
);
    logic [7:0] mem_q [0:8191];
    logic [7:0] lo_q;
    logic [4:0] hi_q;
    logic       rw_clash_q = 1'b0;
    logic       no_ce_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Halves persist until their own strobe rises again
    always @(posedge i_low_addr_strobe_n) lo_q = i_bus;
    always @(posedge i_high_addr_strobe_n) hi_q = i_bus[4:0];
    ////////////////////////////////////////////////////////////////////////////
    // Late data is stored as seen, so a readback exposes it
    always @(negedge i_write_en_n) begin
        if (i_chip_en_n === 1'b0) mem_q[{hi_q, lo_q}] = i_bus;
    end
    assign o_bus_oe = !i_chip_en_n && !i_read_en_n;
    assign o_bus    = mem_q[{hi_q, lo_q}];
    ////////////////////////////////////////////////////////////////////////////
    // Host side faults are flagged sticky for the bench
    assign o_err = {no_ce_q, rw_clash_q};
    always @(negedge i_write_en_n or negedge i_read_en_n) begin
        if (i_write_en_n === 1'b0 && i_read_en_n === 1'b0) rw_clash_q = 1'b1;
        if (i_chip_en_n !== 1'b0) no_ce_q = 1'b1;
    end
endmodule : mxsp_mem_model
`default_nettype wire

// File: mxsp_pkg.sv
// Types for the multiplexed memory host port.
// Assumes mxsp_map.svh is available on the include path.
`default_nettype none
package mxsp_pkg;
    typedef enum logic [3:0] {
        MXSP_IDLE   = 4'h0,
        MXSP_LO_SET = 4'h1,
        MXSP_LO_STB = 4'h2,
        MXSP_HI_SET = 4'h3,
        MXSP_HI_STB = 4'h4,
        MXSP_GAP    = 4'h5,
        MXSP_WR_SET = 4'h6,
        MXSP_WR_STB = 4'h7,
        MXSP_RD_STB = 4'h8,
        MXSP_RD_HIZ = 4'h9
    } mxsp_state_t;
endpackage : mxsp_pkg
`default_nettype wire

// File: mxsp_tb.sv
// Self-checking bench for the multiplexed memory host port.
// Assumes mxsp_host and mxsp_mem_model; undriven bus shows a toggling pattern.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import mxsp_pkg::*;
    logic        i_clk_sys;
    logic        i_rst_b;
    logic        i_req;
    logic        i_req_write;
    logic [12:0] i_req_addr;
    logic [7:0]  i_req_wdata;
    logic        rdy;
    logic        vld;
    logic [7:0]  rdat;
    logic        ce_n;
    logic        las_n;
    logic        has_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  hbus;
    logic        hoe;
    logic [7:0]  dbus;
    logic        doe;
    logic [1:0]  err;
    logic [7:0]  float_q = 8'h5a;
    wire  [7:0]  bus;
    logic [7:0]  lo_cnt = 8'h00;
    logic [7:0]  hi_cnt = 8'h00;
    logic [7:0]  lo_n;
    logic [7:0]  hi_n;
    logic [7:0]  rd_v;
    logic [7:0]  clash = 8'h00;
    int          fail_count;
    int          num_checks;
    ////////////////////////////////////////////////////////////////////////////
    mxsp_host DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_req(i_req),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .o_req_ready(rdy), .o_rsp_valid(vld), .o_rsp_rdata(rdat), .o_chip_en_n(ce_n),
        .o_low_addr_strobe_n(las_n), .o_high_addr_strobe_n(has_n), .o_read_en_n(rd_n),
        .o_write_en_n(wr_n), .i_shared_addr_data_bus(bus), .o_shared_addr_data_bus(hbus),
        .o_shared_addr_data_bus_oe(hoe));
    mxsp_mem_model u_mem (.i_chip_en_n(ce_n), .i_low_addr_strobe_n(las_n),
        .i_high_addr_strobe_n(has_n), .i_read_en_n(rd_n), .i_write_en_n(wr_n),
        .i_bus(bus), .o_bus(dbus), .o_bus_oe(doe), .o_err(err));
    // Released bus changes every cycle so a stale value never passes
    assign bus = hoe ? hbus : (doe ? dbus : float_q);
    always #12.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) float_q <= ~float_q;
    always @(posedge i_clk_sys) if (hoe && doe) clash <= clash + 8'h01;
    always @(negedge las_n) lo_cnt <= lo_cnt + 8'h01;
    always @(negedge has_n) hi_cnt <= hi_cnt + 8'h01;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
        int n;
        logic [7:0] lo_b;
        logic [7:0] hi_b;
        n = 0;
        lo_b = lo_cnt;
        hi_b = hi_cnt;
        @(posedge i_clk_sys);
        i_req       <= 1'b1;
        i_req_write <= w;
        i_req_addr  <= a;
        i_req_wdata <= d;
        @(negedge i_clk_sys);
        while (rdy !== 1'b1 && n < 50) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 50) chk(8'h00, 8'h01, "never ready");
        @(posedge i_clk_sys);
        i_req <= 1'b0;
        n = 0;
        @(negedge i_clk_sys);
        while (vld !== 1'b1 && n < 100) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 100) chk(8'h00, 8'h01, "no response");
        rd_v = rdat;
        lo_n = lo_cnt - lo_b;
        hi_n = hi_cnt - hi_b;
    endtask : acc
    task automatic t_fresh;
        acc(1'b1, 13'h0a5c, 8'h3c);
        chk(lo_n, 8'h01, "low strobes");
        chk(hi_n, 8'h01, "high strobes");
        chk(u_mem.mem_q[13'h0a5c], 8'h3c, "stored byte");
        acc(1'b0, 13'h0a5c, 8'h00);
        chk(rd_v, 8'h3c, "read byte");
        chk(lo_n | hi_n, 8'h00, "strobes on same address");
    endtask : t_fresh
    task automatic t_skip;
        acc(1'b1, 13'h0a11, 8'hc3);
        chk(lo_n, 8'h01, "low strobes, same high");
        chk(hi_n, 8'h00, "high strobes, same high");
        chk(u_mem.mem_q[13'h0a11], 8'hc3, "byte, same high");
        acc(1'b1, 13'h1311, 8'h96);
        chk(lo_n, 8'h00, "low strobes, same low");
        chk(hi_n, 8'h01, "high strobes, same low");
        chk(u_mem.mem_q[13'h1311], 8'h96, "byte, same low");
        chk(u_mem.mem_q[13'h0a11], 8'hc3, "neighbour kept");
    endtask : t_skip
    task automatic t_bounds;
        acc(1'b1, 13'h0000, 8'h81);
        acc(1'b1, 13'h1fff, 8'h7e);
        acc(1'b0, 13'h0000, 8'h00);
        chk(rd_v, 8'h81, "bottom byte");
        acc(1'b0, 13'h1fff, 8'h00);
        chk(rd_v, 8'h7e, "top byte");
    endtask : t_bounds
    task automatic t_proto;
        chk({7'h00, err[0]}, 8'h00, "read and write together");
        chk({7'h00, err[1]}, 8'h00, "strobe without chip enable");
        chk(clash, 8'h00, "bus contention");
        chk({7'h00, hoe}, 8'h00, "bus left driven");
    endtask : t_proto
    task automatic test_done;
        $display("Checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys   = 1'b0;
        i_rst_b     = 1'b0;
        i_req       = 1'b0;
        i_req_write = 1'b0;
        i_req_addr  = 13'h0000;
        i_req_wdata = 8'h00;
        fail_count  = 0;
        num_checks  = 0;
        repeat (5) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        t_fresh();
        t_skip();
        t_bounds();
        t_proto();
        test_done();
    end
    // Eight accesses need about 150 cycles; this waits 4000
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule : tb
`default_nettype wire
